// ==== core/hpm_top.sv ====
// hpm_top: host port mode select, strobe decode, byte register file, serial
// slave, interrupt gating and apb control registers.
// assumes host pins asynchronous; event inputs and apb run on I_CLK.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module hpm_top
   import hpm_pkg::*;
#(
   parameter int unsigned HOST_AW = HOST_AW_DEF,
   parameter int unsigned REG_AW = REG_AW_DEF
)
(
   // clock, reset, enable
   input wire logic I_CLK,
   input wire logic I_RESETN,
   input wire logic I_CE,
   // mode pins
   input wire logic I_SERIAL_PORT_SELECT,
   input wire logic I_BUS_STYLE_SELECT,
   // host port pins
   input wire logic I_CHIP_SELECT_N,
   input wire logic I_READ_STROBE_N,
   input wire logic I_WRITE_STROBE_N,
   input wire logic [HOST_AW-1:0] I_HOST_ADDR,
   input wire logic [7:0] I_HOST_DATA,
   output logic [7:0] O_HOST_DATA,
   output logic [7:0] O_HOST_DATA_OE,
   // open-drain interrupt pin
   output logic O_IRQ_N,
   output logic O_IRQ_N_OE,
   // event sources
   input wire logic I_FRAMER_EVT,
   input wire logic I_LINE_EVT,
   input wire logic I_BITERR_EVT,
   // apb slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR
);

   localparam int unsigned DEPTH = 1 << REG_AW;
   localparam int unsigned SW = 5 + HOST_AW + 8;
   localparam logic [SW-1:0] SYNC_RST = {2'h0, 3'h7, {(HOST_AW + 8){1'b0}}};

   // parameters the logic cannot serve
   if (REG_AW == 0 || REG_AW > SPI_ADDR_W || REG_AW > HOST_AW)
   begin : g_bad_width
      $error("hpm_top: REG_AW must be 1..7 and not above HOST_AW");
   end

   // synchronised pins
   logic [SW-1:0] sync_out;
   logic spi_sel_q;
   logic style_q;
   logic cs_n_q;
   logic rd_n_q;
   logic wr_n_q;
   logic [HOST_AW-1:0] addr_q;
   logic [7:0] data_q;

   hpm_sync #(.W(SW), .RST_VAL(SYNC_RST)) u_sync
   (
      .i_clk(I_CLK),
      .i_resetn(I_RESETN),
      .i_ce(I_CE),
      .i_async({I_SERIAL_PORT_SELECT, I_BUS_STYLE_SELECT, I_CHIP_SELECT_N,
                I_READ_STROBE_N, I_WRITE_STROBE_N, I_HOST_ADDR, I_HOST_DATA}),
      .o_sync(sync_out)
   );

   assign {spi_sel_q, style_q, cs_n_q, rd_n_q, wr_n_q, addr_q, data_q} = sync_out;

   // storage
   logic [7:0] regs_ff [DEPTH];
   logic [7:0] nxt_regs [DEPTH];

   // {read active, write active} for either strobe style
   function automatic logic [1:0] strobe_decode(input logic style, input logic rd_n,
                                                input logic wr_n);
      logic [1:0] res;
      if (style)
         res = {~rd_n & wr_n, ~rd_n & ~wr_n};
      else
         res = {~rd_n, ~wr_n};
      return res;
   endfunction

   // register byte shared by parallel and serial reads
   function automatic logic [7:0] read_byte(input logic [REG_AW-1:0] idx);
      return regs_ff[idx];
   endfunction

   // parallel strobe decode and write capture
   logic par_rd_act;
   logic par_wr_act;
   logic par_wr_pulse;
   logic par_hit;
   logic wr_act_prev_ff;
   logic cs_n_prev_ff;
   logic whit_ff;
   logic [REG_AW-1:0] widx_ff;
   logic [7:0] wdata_ff;
   logic nxt_wr_act_prev;
   logic nxt_cs_n_prev;
   logic nxt_whit;
   logic [REG_AW-1:0] nxt_widx;
   logic [7:0] nxt_wdata;

   assign {par_rd_act, par_wr_act} = strobe_decode(style_q, rd_n_q, wr_n_q);
   assign par_hit = (addr_q >> REG_AW) == '0;
   // end of write strobe while selected; select high blocks it
   assign par_wr_pulse = !spi_sel_q && wr_act_prev_ff && !par_wr_act && !cs_n_prev_ff;

   // address and data are held during the strobe so a short hold time is safe
   always_comb
   begin
      nxt_wr_act_prev = par_wr_act & ~cs_n_q;
      nxt_cs_n_prev = cs_n_q;
      nxt_whit = whit_ff;
      nxt_widx = widx_ff;
      nxt_wdata = wdata_ff;
      if (par_wr_act && !cs_n_q)
      begin
         nxt_whit = par_hit;
         nxt_widx = addr_q[REG_AW-1:0];
         nxt_wdata = data_q;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         wr_act_prev_ff <= 1'b0;
         cs_n_prev_ff <= 1'b1;
         whit_ff <= 1'b0;
         widx_ff <= '0;
         wdata_ff <= RST_REG_BYTE;
      end
      else if (I_CE)
      begin
         wr_act_prev_ff <= nxt_wr_act_prev;
         cs_n_prev_ff <= nxt_cs_n_prev;
         whit_ff <= nxt_whit;
         widx_ff <= nxt_widx;
         wdata_ff <= nxt_wdata;
      end
   end

   // serial slave, mode 0, control byte then data byte
   hpm_spi_state_type spi_st_ff;
   hpm_spi_state_type nxt_spi_st;
   logic sclk_prev_ff;
   logic [2:0] spi_cnt_ff;
   logic [7:0] spi_sh_ff;
   logic [7:0] spi_tx_ff;
   logic [SPI_ADDR_W-1:0] spi_addr_ff;
   logic spi_rw_ff;
   logic spi_miso_ff;
   logic [2:0] nxt_spi_cnt;
   logic [7:0] nxt_spi_sh;
   logic [7:0] nxt_spi_tx;
   logic [SPI_ADDR_W-1:0] nxt_spi_addr;
   logic nxt_spi_rw;
   logic nxt_spi_miso;
   logic spi_wr_pulse;
   logic sclk_q;
   logic sclk_rise;
   logic sclk_fall;

   assign sclk_q = data_q[PIN_SCLK];
   assign sclk_rise = sclk_q & ~sclk_prev_ff;
   assign sclk_fall = ~sclk_q & sclk_prev_ff;

   always_comb
   begin
      nxt_spi_st = spi_st_ff;
      nxt_spi_cnt = spi_cnt_ff;
      nxt_spi_sh = spi_sh_ff;
      nxt_spi_tx = spi_tx_ff;
      nxt_spi_addr = spi_addr_ff;
      nxt_spi_rw = spi_rw_ff;
      nxt_spi_miso = spi_miso_ff;
      spi_wr_pulse = 1'b0;
      case (spi_st_ff)
         SPI_IDLE:
         begin
            nxt_spi_cnt = 3'h0;
            if (spi_sel_q && !cs_n_q)
               nxt_spi_st = SPI_CMD;
         end
         SPI_CMD:
         begin
            if (sclk_rise)
            begin
               nxt_spi_sh = {spi_sh_ff[6:0], data_q[PIN_MOSI]};
               nxt_spi_cnt = spi_cnt_ff + 3'h1;
               if (spi_cnt_ff == SPI_LAST)
               begin
                  nxt_spi_rw = nxt_spi_sh[SPI_RW_BIT];
                  nxt_spi_addr = nxt_spi_sh[SPI_ADDR_W-1:0];
                  nxt_spi_tx = ((nxt_spi_sh[SPI_ADDR_W-1:0] >> REG_AW) == '0) ?
                               read_byte(nxt_spi_sh[REG_AW-1:0]) : 8'h00;
                  nxt_spi_st = SPI_DATA;
               end
            end
         end
         SPI_DATA:
         begin
            // data out changes on the falling edge, ready for the next rise
            if (sclk_fall && spi_rw_ff)
            begin
               nxt_spi_miso = spi_tx_ff[7];
               nxt_spi_tx = {spi_tx_ff[6:0], 1'b0};
            end
            if (sclk_rise)
            begin
               nxt_spi_sh = {spi_sh_ff[6:0], data_q[PIN_MOSI]};
               nxt_spi_cnt = spi_cnt_ff + 3'h1;
               if (spi_cnt_ff == SPI_LAST)
               begin
                  spi_wr_pulse = !spi_rw_ff && ((spi_addr_ff >> REG_AW) == '0);
                  nxt_spi_st = SPI_END;
               end
            end
         end
         SPI_END:
            nxt_spi_cnt = 3'h0;
         default:
            nxt_spi_st = SPI_IDLE;
      endcase
      // deselect aborts any frame; one byte pair per select only
      if (cs_n_q || !spi_sel_q)
      begin
         nxt_spi_st = SPI_IDLE;
         nxt_spi_miso = 1'b0;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         spi_st_ff <= SPI_IDLE;
         sclk_prev_ff <= 1'b0;
         spi_cnt_ff <= 3'h0;
         spi_sh_ff <= 8'h00;
         spi_tx_ff <= 8'h00;
         spi_addr_ff <= '0;
         spi_rw_ff <= 1'b0;
         spi_miso_ff <= 1'b0;
      end
      else if (I_CE)
      begin
         spi_st_ff <= nxt_spi_st;
         sclk_prev_ff <= sclk_q;
         spi_cnt_ff <= nxt_spi_cnt;
         spi_sh_ff <= nxt_spi_sh;
         spi_tx_ff <= nxt_spi_tx;
         spi_addr_ff <= nxt_spi_addr;
         spi_rw_ff <= nxt_spi_rw;
         spi_miso_ff <= nxt_spi_miso;
      end
   end

   // register file and host data pins
   logic [7:0] rd_data_ff;
   logic [7:0] oe_ff;
   logic [7:0] nxt_rd_data;
   logic [7:0] nxt_oe;

   always_comb
   begin
      for (int i = 0; i < DEPTH; i++)
         nxt_regs[i] = regs_ff[i];
      if (par_wr_pulse && whit_ff)
         nxt_regs[widx_ff] = wdata_ff;
      if (spi_wr_pulse)
         nxt_regs[spi_addr_ff[REG_AW-1:0]] = nxt_spi_sh;
      nxt_rd_data = 8'h00;
      nxt_oe = 8'h00;
      if (spi_sel_q)
      begin
         nxt_rd_data[PIN_MISO] = spi_miso_ff;
         nxt_oe[PIN_MISO] = !cs_n_q;
      end
      else
      begin
         nxt_rd_data = par_hit ? read_byte(addr_q[REG_AW-1:0]) : 8'h00;
         nxt_oe = {8{par_rd_act & ~cs_n_q}};
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         for (int i = 0; i < DEPTH; i++)
            regs_ff[i] <= RST_REG_BYTE;
         rd_data_ff <= 8'h00;
         oe_ff <= 8'h00;
      end
      else if (I_CE)
      begin
         for (int i = 0; i < DEPTH; i++)
            regs_ff[i] <= nxt_regs[i];
         rd_data_ff <= nxt_rd_data;
         oe_ff <= nxt_oe;
      end
   end

   assign O_HOST_DATA = rd_data_ff;
   assign O_HOST_DATA_OE = oe_ff;

   // apb registers and interrupt gating
   logic [NUM_SRC-1:0] status_ff;
   logic [NUM_SRC-1:0] enable_ff;
   logic glob_ff;
   logic irq_ff;
   logic ready_ff;
   logic err_ff;
   logic [31:0] prdata_ff;
   logic [NUM_SRC-1:0] nxt_status;
   logic [NUM_SRC-1:0] nxt_enable;
   logic [NUM_SRC-1:0] evt;
   logic [NUM_SRC-1:0] clr;
   logic nxt_glob;
   logic nxt_irq;
   logic nxt_ready;
   logic nxt_err;
   logic [31:0] nxt_prdata;
   logic apb_wr;

   function automatic logic apb_mapped(input logic [11:0] a);
      return a == OFF_IRQ_STATUS || a == OFF_IRQ_CLEAR || a == OFF_IRQ_ENABLE ||
             a == OFF_CONTROL || a == OFF_PORT_STATE;
   endfunction

   // ready is gated by the enable so a transfer completes only on a live edge
   assign O_PREADY = ready_ff & I_CE;
   assign O_PSLVERR = ready_ff & err_ff & I_CE;
   assign O_PRDATA = prdata_ff;
   assign apb_wr = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;

   always_comb
   begin
      evt = '0;
      evt[SRC_FRAMER] = I_FRAMER_EVT;
      evt[SRC_LINE] = I_LINE_EVT;
      evt[SRC_BITERR] = I_BITERR_EVT;
      evt[SRC_HOSTWR] = par_wr_pulse | spi_wr_pulse;
      clr = (apb_wr && I_PADDR == OFF_IRQ_CLEAR) ? I_PWDATA[NUM_SRC-1:0] : '0;
      nxt_status = (status_ff & ~clr) | evt; // set wins over clear
      nxt_enable = (apb_wr && I_PADDR == OFF_IRQ_ENABLE) ? I_PWDATA[NUM_SRC-1:0] : enable_ff;
      nxt_glob = (apb_wr && I_PADDR == OFF_CONTROL) ? I_PWDATA[CTRL_GLOBAL_BIT] : glob_ff;
      nxt_irq = glob_ff & |(status_ff & enable_ff);
      nxt_ready = ready_ff;
      nxt_err = err_ff;
      nxt_prdata = prdata_ff;
      if (I_PSEL && I_PENABLE && ready_ff)
         nxt_ready = 1'b0;
      else if (I_PSEL && !I_PENABLE)
      begin
         nxt_ready = 1'b1;
         nxt_err = !apb_mapped(I_PADDR);
         nxt_prdata = 32'h0000_0000;
         case (I_PADDR)
            OFF_IRQ_STATUS: nxt_prdata[NUM_SRC-1:0] = status_ff;
            OFF_IRQ_ENABLE: nxt_prdata[NUM_SRC-1:0] = enable_ff;
            OFF_CONTROL: nxt_prdata[CTRL_GLOBAL_BIT] = glob_ff;
            OFF_PORT_STATE:
            begin
               nxt_prdata[PST_SPI_BIT] = spi_sel_q;
               nxt_prdata[PST_STYLE_BIT] = style_q;
               nxt_prdata[PST_BUSY_BIT] = !cs_n_q;
            end
            default: nxt_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESETN)
   begin
      if (!I_RESETN)
      begin
         status_ff <= RST_IRQ_STATUS;
         enable_ff <= RST_IRQ_ENABLE;
         glob_ff <= RST_GLOBAL_EN;
         irq_ff <= 1'b0;
         ready_ff <= 1'b0;
         err_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end
      else if (I_CE)
      begin
         status_ff <= nxt_status;
         enable_ff <= nxt_enable;
         glob_ff <= nxt_glob;
         irq_ff <= nxt_irq;
         ready_ff <= nxt_ready;
         err_ff <= nxt_err;
         prdata_ff <= nxt_prdata;
      end
   end

   // open drain: only ever drives low
   assign O_IRQ_N = 1'b0;
   assign O_IRQ_N_OE = irq_ff;

   // checks
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RESETN);

   chk_spi_pin_use: assert property (spi_sel_q && oe_ff == nxt_oe |-> O_HOST_DATA_OE[7:1] == 7'h00)
      else $error("serial mode drives parallel data pins");
   chk_par_read_drive: assert property (!$past(spi_sel_q) && O_HOST_DATA_OE != 8'h00 && $past(I_CE)
      |-> $past(!cs_n_q && par_rd_act))
      else $error("data bus driven outside a read");
   chk_cs_ignore: assert property (I_CE && cs_n_q ##1 I_CE |-> !par_wr_pulse)
      else $error("write taken while deselected");
   chk_wr_capture: assert property (I_CE && par_wr_pulse && whit_ff
      |=> regs_ff[$past(widx_ff)] == $past(wdata_ff))
      else $error("parallel write not stored");
   chk_strobe_dir_write: assert property (I_CE && style_q && !spi_sel_q && !cs_n_q && !rd_n_q && !wr_n_q
      |=> O_HOST_DATA_OE == 8'h00)
      else $error("data driven during strobed write");
   chk_sep_read_drive: assert property (I_CE && !style_q && !spi_sel_q && !cs_n_q && !rd_n_q
      |=> O_HOST_DATA_OE == 8'hff)
      else $error("read strobe did not drive bus");
   chk_irq_assert: assert property (I_CE && glob_ff && (status_ff & enable_ff) != '0
      |=> O_IRQ_N_OE)
      else $error("unmasked event not signalled");
   chk_irq_release: assert property ($fell(O_IRQ_N_OE)
      |-> $past(!glob_ff || (status_ff & enable_ff) == '0))
      else $error("interrupt released while pending");
   chk_mask_global: assert property (!glob_ff ##1 !glob_ff |-> !O_IRQ_N_OE)
      else $error("global mask ignored");
   chk_event_set_wins: assert property (I_CE && I_FRAMER_EVT |=> status_ff[SRC_FRAMER])
      else $error("event lost");
   chk_mode_select: assert property (I_CE && !spi_sel_q |=> spi_st_ff == SPI_IDLE)
      else $error("serial slave active in parallel mode");

endmodule
`default_nettype wire

// ==== core/hpm_pkg.sv ====
// hpm_pkg: constants, offsets, reset values and types of the host port block.
// assumes one 50 MHz clock; pin inputs are asynchronous to it.
//
// Behaviour
// - serial_port_select 0 gives the 8-bit parallel port, 1 the serial port.
// - bus_style_select high: data strobe plus direction; low: separate read/write strobes.
// - strobe pins are decoded according to bus_style_select.
// - irq_n is pulled low while any unmasked event is pending.
// - irq_n is released once no unmasked source is pending (cleared or masked) or the global enable is cleared.
// - a source reaches irq_n only if unmasked globally and at its own level.
// - master_reset_n low resets all registers and port logic.
// - parallel read drives host_data only while read strobe and chip select are low.
// - parallel write captures host_data at the end of the write strobe.
// - serial mode reuses data pins as serial clock, data in and data out.
package hpm_pkg;

   // default widths
   localparam int unsigned HOST_AW_DEF = 10;
   localparam int unsigned REG_AW_DEF = 4;
   localparam int unsigned SPI_ADDR_W = 7;

   // apb byte offsets
   localparam logic [11:0] OFF_IRQ_STATUS = 12'h000;
   localparam logic [11:0] OFF_IRQ_CLEAR = 12'h004;
   localparam logic [11:0] OFF_IRQ_ENABLE = 12'h008;
   localparam logic [11:0] OFF_CONTROL = 12'h00c;
   localparam logic [11:0] OFF_PORT_STATE = 12'h010;

   // interrupt source positions
   localparam int unsigned NUM_SRC = 4;
   localparam int unsigned SRC_FRAMER = 0;
   localparam int unsigned SRC_LINE = 1;
   localparam int unsigned SRC_BITERR = 2;
   localparam int unsigned SRC_HOSTWR = 3;

   // control and port state fields
   localparam int unsigned CTRL_GLOBAL_BIT = 0;
   localparam int unsigned PST_SPI_BIT = 0;
   localparam int unsigned PST_STYLE_BIT = 1;
   localparam int unsigned PST_BUSY_BIT = 2;

   // reset values
   localparam logic [NUM_SRC-1:0] RST_IRQ_STATUS = 4'h0;
   localparam logic [NUM_SRC-1:0] RST_IRQ_ENABLE = 4'h0;
   localparam logic RST_GLOBAL_EN = 1'b0;
   localparam logic [7:0] RST_REG_BYTE = 8'h00;

   // serial port: pin reuse and framing
   localparam int unsigned PIN_SCLK = 2;
   localparam int unsigned PIN_MOSI = 1;
   localparam int unsigned PIN_MISO = 0;
   localparam int unsigned SPI_RW_BIT = 7;
   localparam logic [2:0] SPI_LAST = 3'h7;

   // serial framing states, gray along idle, command, data, end
   typedef enum logic [1:0]
   {
      SPI_IDLE = 2'h0,
      SPI_CMD = 2'h1,
      SPI_DATA = 2'h3,
      SPI_END = 2'h2
   } hpm_spi_state_type;

endpackage

// ==== core/hpm_sync.sv ====
// hpm_sync: three-stage synchroniser with agreement filter, one per bit.
// assumes asynchronous inputs; output changes once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module hpm_sync
#(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   // data
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] out_ff;
   logic [W-1:0] nxt_out;

   // a bit only moves when the last two stages agree, masking a late settle
   always_comb
   begin
      for (int b = 0; b < W; b++)
         nxt_out[b] = (s2_ff[b] == s3_ff[b]) ? s3_ff[b] : out_ff[b];
   end

   // meta_ff feeds s2_ff and nothing else
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         meta_ff <= RST_VAL;
         s2_ff <= RST_VAL;
         s3_ff <= RST_VAL;
         out_ff <= RST_VAL;
      end
      else if (i_ce)
      begin
         meta_ff <= i_async;
         s2_ff <= meta_ff;
         s3_ff <= s2_ff;
         out_ff <= nxt_out;
      end
   end

   assign o_sync = out_ff;

endmodule
`default_nettype wire

// ==== sim/hpm_host_model.sv ====
// hpm_host_model: microprocessor on the host pins, parallel or serial.
// assumes the bench resolves the data bus from this drive and the enables.
`timescale 1ns/100ps
`default_nettype none
module hpm_host_model
(
   // clock and mode
   input wire logic i_clk,
   input wire logic i_style,
   // resolved data bus and device enables
   input wire logic [7:0] i_bus,
   input wire logic [7:0] i_oe,
   // host pins
   output logic o_cs_n,
   output logic o_rd_n,
   output logic o_wr_n,
   output logic [9:0] o_addr,
   output logic [7:0] o_data
);
   // idle: deselected, strobes high, sclk low
   initial
   begin
      o_cs_n = 1'b1;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_addr = '0;
      o_data = 8'h00;
   end
   task automatic tick(input int k);
      repeat (k) @(posedge i_clk);
   endtask
   // parallel write; cs may stay high to offer a strobe that must be ignored
   task automatic pwr(input logic cs, input logic [9:0] a, input logic [7:0] d);
      o_cs_n <= ~cs;
      o_addr <= a;
      o_data <= d;
      if (i_style)
         o_wr_n <= 1'b0; // direction select low means write
      tick(2);
      if (i_style)
         o_rd_n <= 1'b0;
      else
         o_wr_n <= 1'b0;
      tick(6);
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1; // rising strobe ends the write
      tick(2);
      o_cs_n <= 1'b1;
      o_data <= ~d; // released bus must not keep the old byte
      tick(8);
   endtask
   // parallel read; waits a bounded time for the device to drive
   task automatic prd(input logic [9:0] a, output logic [7:0] d, output logic ok);
      o_addr <= a;
      o_cs_n <= 1'b0;
      tick(2);
      o_rd_n <= 1'b0; // read strobe or data strobe with direction high
      ok = 1'b0;
      for (int n = 0; n < 20 && !ok; n++)
      begin
         @(negedge i_clk);
         ok = (i_oe === 8'hff);
      end
      d = i_bus;
      @(posedge i_clk);
      o_rd_n <= 1'b1;
      tick(2);
      o_cs_n <= 1'b1;
      tick(8);
   endtask
   // serial frame, msb first: mosi set with sclk low, miso taken before rise
   task automatic sxfer(input logic [15:0] w, output logic [7:0] d);
      o_cs_n <= 1'b0;
      for (int n = 15; n >= 0; n--)
      begin
         o_data <= {5'h00, 1'b0, w[n], 1'b0};
         // miso lands about six clocks after the fall: sync, shift, output flop
         tick(7);
         @(negedge i_clk);
         d = {d[6:0], i_bus[0]};
         @(posedge i_clk);
         o_data <= {5'h00, 1'b1, w[n], 1'b0};
         tick(5);
      end
      o_data <= 8'h00; // sclk stands low between frames
      tick(5);
      o_cs_n <= 1'b1;
      tick(8);
   endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// tb: apb and host pin sequences with expected values for hpm_top.
// assumes mode pins change only inside reset; irq pin pulled up on board.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import hpm_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic spi_sel = 1'b0;
   logic style_sel = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [2:0] evt = '0;
   logic [31:0] rv;
   logic er;
   logic [7:0] bv;
   logic ok;
   int miscompares = 0;
   int cmp_count = 0;
   wire logic cs_n;
   wire logic rd_n;
   wire logic wr_n;
   wire logic [9:0] addr;
   wire logic [7:0] hdrv;
   wire logic [7:0] hout;
   wire logic [7:0] hoe;
   wire logic irq_oe;
   wire logic irq_v;
   wire logic [31:0] prdata;
   wire logic pready;
   wire logic pslverr;
   // each bus bit: device when enabled, else host; irq pin has a pull-up
   wire logic [7:0] bus = (hoe & hout) | (~hoe & hdrv);
   wire logic irq_pin = irq_oe ? irq_v : 1'b1;
   always #10 clk = ~clk;
   hpm_top uut
   (
      .I_CLK(clk),
      .I_RESETN(rst_n),
      .I_CE(1'b1),
      .I_SERIAL_PORT_SELECT(spi_sel),
      .I_BUS_STYLE_SELECT(style_sel),
      .I_CHIP_SELECT_N(cs_n),
      .I_READ_STROBE_N(rd_n),
      .I_WRITE_STROBE_N(wr_n),
      .I_HOST_ADDR(addr),
      .I_HOST_DATA(bus),
      .O_HOST_DATA(hout),
      .O_HOST_DATA_OE(hoe),
      .O_IRQ_N(irq_v),
      .O_IRQ_N_OE(irq_oe),
      .I_FRAMER_EVT(evt[0]),
      .I_LINE_EVT(evt[1]),
      .I_BITERR_EVT(evt[2]),
      .I_PSEL(psel),
      .I_PENABLE(penable),
      .I_PWRITE(pwrite),
      .I_PADDR(paddr),
      .I_PWDATA(pwdata),
      .O_PRDATA(prdata),
      .O_PREADY(pready),
      .O_PSLVERR(pslverr)
   );
   hpm_host_model host
   (
      .i_clk(clk),
      .i_style(style_sel),
      .i_bus(bus),
      .i_oe(hoe),
      .o_cs_n(cs_n),
      .o_rd_n(rd_n),
      .o_wr_n(wr_n),
      .o_addr(addr),
      .o_data(hdrv)
   );
   task automatic summarize();
      $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // one apb transfer; ready, data and error are taken at the completing rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge clk);
         if (pready === 1'b1 && psel === 1'b1 && penable === 1'b1)
            break;
      end
      if (k == 50)
      begin
         miscompares++;
         $display("mismatch at %0t: no pready", $time);
         summarize();
      end
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // mode pins move only while reset is held
   task automatic reboot(input logic s, input logic b);
      rst_n <= 1'b0;
      spi_sel <= s;
      style_sel <= b;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
   task automatic fire(input int i);
      @(posedge clk);
      evt[i] <= 1'b1;
      @(posedge clk);
      evt <= '0;
      repeat (3) @(negedge clk);
   endtask
   task automatic settle();
      repeat (3) @(negedge clk);
   endtask
   initial
   begin
      reboot(1'b0, 1'b0);
      apb(1'b0, OFF_IRQ_STATUS, 0);
      chk(rv, 0);
      apb(1'b0, OFF_PORT_STATE, 0);
      chk(rv, 0);
      chk(32'(irq_pin), 1);
      apb(1'b0, 12'h0fc, 0);
      chk(32'(er), 1);
      $display("test reset done");
      // separate strobes: write, ignored write, read back, unmapped read
      host.pwr(1'b1, 10'h003, 8'ha5);
      host.pwr(1'b0, 10'h003, 8'h5a);
      host.prd(10'h003, bv, ok);
      chk(32'({ok, bv}), 32'h1a5);
      chk(32'(hoe), 0);
      host.prd(10'h3f3, bv, ok);
      chk(32'({ok, bv}), 32'h100);
      apb(1'b0, OFF_IRQ_STATUS, 0);
      chk(rv, 8);
      apb(1'b1, OFF_IRQ_CLEAR, 8);
      $display("test parallel done");
      // framer, line and bit error sources: global mask, own mask, clear
      apb(1'b1, OFF_IRQ_ENABLE, 7);
      for (int i = 0; i < 3; i++)
      begin
         fire(i);
         chk(32'(irq_pin), 1);
         apb(1'b1, OFF_CONTROL, 1);
         settle();
         chk(32'(irq_pin), 0);
         apb(1'b1, OFF_IRQ_ENABLE, 7 & ~(1 << i));
         settle();
         chk(32'(irq_pin), 1);
         apb(1'b1, OFF_IRQ_ENABLE, 7);
         apb(1'b0, OFF_IRQ_STATUS, 0);
         chk(rv, 1 << i);
         apb(1'b1, OFF_IRQ_CLEAR, 1 << i);
         settle();
         chk(32'(irq_pin), 1);
         apb(1'b1, OFF_CONTROL, 0);
      end
      // two pending: pin stays low until both are cleared
      fire(0);
      fire(2);
      apb(1'b1, OFF_CONTROL, 1);
      apb(1'b1, OFF_IRQ_CLEAR, 1);
      settle();
      chk(32'(irq_pin), 0);
      apb(1'b1, OFF_IRQ_CLEAR, 4);
      settle();
      chk(32'(irq_pin), 1);
      $display("test irq done");
      // data strobe with direction select
      reboot(1'b0, 1'b1);
      apb(1'b0, OFF_PORT_STATE, 0);
      chk(rv, 2);
      host.pwr(1'b1, 10'h005, 8'h3c);
      host.prd(10'h005, bv, ok);
      chk(32'({ok, bv}), 32'h13c);
      $display("test strobe style done");
      // serial port: reset cleared the file, then write and read back
      reboot(1'b1, 1'b0);
      apb(1'b0, OFF_PORT_STATE, 0);
      chk(rv, 1);
      host.sxfer({1'b1, 7'h03, 8'h00}, bv);
      chk(32'(bv), 0);
      host.sxfer({1'b0, 7'h06, 8'hc3}, bv);
      host.sxfer({1'b1, 7'h06, 8'h00}, bv);
      chk(32'(bv), 32'hc3);
      $display("test serial done");
      summarize();
   end
endmodule
`default_nettype wire
